// ==== rtl/tmc_pkg.sv ====
package tmc_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [7:0] TMC_ADDR_CONTROL = 8'hC8;
    localparam logic [7:0] TMC_ADDR_MODE = 8'hC9;
    localparam logic [7:0] TMC_ADDR_CNT_LO = 8'hCA;
    localparam logic [7:0] TMC_ADDR_CNT_HI = 8'hCB;
    localparam logic [7:0] TMC_ADDR_RLD_LO = 8'hCC;
    localparam logic [7:0] TMC_ADDR_RLD_HI = 8'hCD;

    // ==========================================================
    // Control register bit positions
    localparam int TMC_BIT_OVF = 7;
    localparam int TMC_BIT_EXT = 6;
    localparam int TMC_BIT_RXSEL = 5;
    localparam int TMC_BIT_TXSEL = 4;
    localparam int TMC_BIT_EXEN = 3;
    localparam int TMC_BIT_RUN = 2;
    localparam int TMC_BIT_SRC = 1;
    localparam int TMC_BIT_CAPSEL = 0;

    // Mode register bit positions
    localparam int TMC_BIT_CLKOE = 1;
    localparam int TMC_BIT_DOWN_COUNT_ENABLE = 0;

    // ==========================================================
    // Reset values and counts
    localparam logic [7:0] TMC_CONTROL_RST = 8'h00;
    localparam logic [1:0] TMC_MODE_RST = 2'h0;
    localparam logic [15:0] TMC_COUNT_RST = 16'h0000;
    localparam logic [15:0] TMC_COUNT_MAX = 16'hFFFF;
    localparam int TMC_PRESC_W = 4;
    localparam logic [TMC_PRESC_W-1:0] TMC_TIMER_DIV = 4'hC;
    localparam logic [TMC_PRESC_W-1:0] TMC_FAST_DIV = 4'h2;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [1:0] mode;
        logic [15:0] count;
        logic [15:0] reload;
        logic [TMC_PRESC_W-1:0] presc;
        logic clk_pin;
        logic rx_tick;
        logic tx_tick;
        logic irq;
        logic [7:0] rdata;
    } tmc_state_s;

    typedef struct packed {
        logic trig_s1;
        logic trig_s2;
        logic trig_s3;
        logic cnt_s1;
        logic cnt_s2;
        logic cnt_s3;
    } tmc_sync_s;

endpackage

// ==== rtl/tmc_pin_if.sv ====
`timescale 1ns/100ps
`default_nettype none

// Synchronised pin events handed from the pin stage to the timer core
interface tmc_pin_if;
    logic trig_level;
    logic trig_fall;
    logic cnt_fall;
    modport src (output trig_level, output trig_fall, output cnt_fall);
    modport dst (input trig_level, input trig_fall, input cnt_fall);
endinterface

`default_nettype wire

// ==== rtl/tmc_pin_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

module tmc_pin_sync
    import tmc_pkg::*;
(
    input wire logic i_clock,     // Oscillator clock
    input wire logic i_nrst,      // Async reset, active low
    input wire logic i_trig_pin,  // Raw trigger pin
    input wire logic i_count_pin, // Raw count pin
    tmc_pin_if.src pin            // Synchronised events
);

    tmc_sync_s s_q;
    tmc_sync_s s_d;

    // ==========================================================
    // Two-flop synchronisers, third stage for edge history
    always_comb begin
        s_d = s_q;
        s_d.trig_s1 = i_trig_pin;
        s_d.trig_s2 = s_q.trig_s1;
        s_d.trig_s3 = s_q.trig_s2;
        s_d.cnt_s1 = i_count_pin;
        s_d.cnt_s2 = s_q.cnt_s1;
        s_d.cnt_s3 = s_q.cnt_s2;
    end

    // Pins idle high so a reset value of one avoids a false edge
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign pin.trig_level = s_q.trig_s2;
    assign pin.trig_fall = s_q.trig_s3 & ~s_q.trig_s2;
    assign pin.cnt_fall = s_q.cnt_s3 & ~s_q.cnt_s2;

endmodule // tmc_pin_sync

`default_nettype wire

// ==== rtl/tmc_timer2.sv ====
// Functional notes
// RULE1 - Software loads a 16-bit start count before clock-output operation.
// RULE2 - Software starts clock output last by setting run control.
// RULE3 - Baud generation and clock output run together from one reload pair.
// RULE4 - Overflow sets flag only without serial clock selects; software clears it.
// RULE5 - Enabled trigger falling edge causing capture or reload sets external flag.
// RULE6 - External flag requests interrupt except in up/down mode; software clears.
// RULE7 - Receive select picks this timer's overflow, else timer 1 overflow.
// RULE8 - Transmit select picks this timer's overflow, else timer 1 overflow.
// RULE9 - Trigger pin ignored unless enabled and not clocking the serial port.
// RULE10 - Counter advances only while run control is one.
// RULE11 - Source select: oscillator divided clock or falling edges on count pin.
// RULE12 - Control register resets to zero and is writable bit by bit.
// RULE13 - Capture select: reload or capture; serial modes force overflow reload.
// RULE14 - Clock-output counts at half oscillator, reloads, toggles pin, no flag.
// RULE15 - Clock output enable turns the count pin into the clock output.
// RULE16 - Up/down mode: trigger high counts up, low counts down to reload.
`timescale 1ns/100ps
`default_nettype none

module tmc_timer2
    import tmc_pkg::*;
(
    input wire logic i_clock,            // 50 MHz oscillator clock
    input wire logic i_nrst,             // Async reset, active low
    input wire logic [7:0] i_sfr_addr,   // Register address
    input wire logic [7:0] i_sfr_wdata,  // Byte write data
    input wire logic i_sfr_wr,           // Byte write strobe
    input wire logic i_sfr_rd,           // Read strobe
    input wire logic i_bit_wr,           // Control bit write strobe
    input wire logic [2:0] i_bit_idx,    // Control bit index
    input wire logic i_bit_val,          // Control bit value
    input wire logic i_trig_pin,         // External trigger pin
    input wire logic i_count_pin,        // Count pin input level
    input wire logic i_t1_ovf,           // Timer 1 overflow pulse
    output logic [7:0] o_sfr_rdata,      // Read data, valid after read
    output logic o_count_pin,            // Count pin output level
    output logic o_count_pin_oe,         // Count pin output enable
    output logic o_rx_clock_tick,        // Serial receive clock tick
    output logic o_tx_clock_tick,        // Serial transmit clock tick
    output logic o_irq                   // Timer interrupt request
);

    tmc_pin_if pin ();

    tmc_pin_sync u_sync (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_trig_pin(i_trig_pin),
        .i_count_pin(i_count_pin),
        .pin(pin)
    );

    tmc_state_s q;
    tmc_state_s s;
    logic baud, clkout, updown, tick, ovf, unf, trig_ev, wr_ctrl;
    logic [TMC_PRESC_W-1:0] div;

    // ==========================================================
    // Next-state logic
    always_comb begin
        s = q;
        baud = q.ctrl[TMC_BIT_RXSEL] | q.ctrl[TMC_BIT_TXSEL];
        clkout = q.mode[TMC_BIT_CLKOE];
        updown = q.mode[TMC_BIT_DOWN_COUNT_ENABLE] & ~baud & ~clkout & ~q.ctrl[TMC_BIT_CAPSEL];
        div = (clkout | baud) ? TMC_FAST_DIV : TMC_TIMER_DIV; // RULE14
        tick = 1'b0;
        ovf = 1'b0;
        unf = 1'b0;
        wr_ctrl = i_sfr_wr && (i_sfr_addr == TMC_ADDR_CONTROL);

        // Prescaler held at zero while stopped so a restart is clean
        if (!q.ctrl[TMC_BIT_RUN]) begin
            s.presc = '0; // RULE10
        end else if (q.ctrl[TMC_BIT_SRC] && !clkout) begin
            tick = pin.cnt_fall; // RULE11
        end else if (q.presc >= div - 1'b1) begin
            s.presc = '0;
            tick = 1'b1; // RULE11
        end else begin
            s.presc = q.presc + 1'b1;
        end

        if (tick) begin
            if (updown && !pin.trig_level) begin
                if (q.count == q.reload) begin
                    s.count = TMC_COUNT_MAX; // RULE16
                    unf = 1'b1;
                end else begin
                    s.count = q.count - 1'b1; // RULE16
                end
            end else if (q.count == TMC_COUNT_MAX) begin
                ovf = 1'b1;
                // Serial and clock-out modes always reload
                if (!q.ctrl[TMC_BIT_CAPSEL] || baud || clkout) begin
                    s.count = q.reload; // RULE13
                end else begin
                    s.count = TMC_COUNT_RST;
                end
            end else begin
                s.count = q.count + 1'b1; // RULE10
            end
        end

        // Up/down mode uses the pin as direction, not as trigger
        trig_ev = pin.trig_fall && q.ctrl[TMC_BIT_EXEN] && !baud && !updown; // RULE9
        if (trig_ev) begin
            if (q.ctrl[TMC_BIT_CAPSEL] && !clkout) begin
                s.reload = q.count; // RULE13
            end else begin
                s.count = q.reload; // RULE13
            end
        end

        if (ovf && clkout) begin
            s.clk_pin = ~q.clk_pin; // RULE14
        end

        // Software writes
        if (wr_ctrl) begin
            s.ctrl = i_sfr_wdata;
        end
        if (i_bit_wr) begin
            s.ctrl[i_bit_idx] = i_bit_val; // RULE12
        end
        if (i_sfr_wr) begin
            unique case (i_sfr_addr)
                TMC_ADDR_MODE: s.mode = i_sfr_wdata[1:0];
                TMC_ADDR_CNT_LO: s.count[7:0] = i_sfr_wdata;
                TMC_ADDR_CNT_HI: s.count[15:8] = i_sfr_wdata;
                TMC_ADDR_RLD_LO: s.reload[7:0] = i_sfr_wdata;
                TMC_ADDR_RLD_HI: s.reload[15:8] = i_sfr_wdata;
                default: ;
            endcase
        end

        // Hardware set wins over a clear in the same cycle
        if ((ovf || unf) && !baud && !clkout) begin
            s.ctrl[TMC_BIT_OVF] = 1'b1; // RULE4
        end
        if (trig_ev) begin
            s.ctrl[TMC_BIT_EXT] = 1'b1; // RULE5
        end else if (updown && (ovf || unf)) begin
            s.ctrl[TMC_BIT_EXT] = ~s.ctrl[TMC_BIT_EXT]; // RULE16
        end

        // Selected serial ticks share the clock-out overflow; unselected ones take timer 1
        s.rx_tick = q.ctrl[TMC_BIT_RXSEL] ? ovf : i_t1_ovf; // RULE3 RULE7
        s.tx_tick = q.ctrl[TMC_BIT_TXSEL] ? ovf : i_t1_ovf; // RULE3 RULE8
        s.irq = s.ctrl[TMC_BIT_OVF] |
            (s.ctrl[TMC_BIT_EXT] & ~s.mode[TMC_BIT_DOWN_COUNT_ENABLE]); // RULE6

        if (i_sfr_rd) begin
            unique case (i_sfr_addr)
                TMC_ADDR_CONTROL: s.rdata = q.ctrl;
                TMC_ADDR_MODE: s.rdata = {6'h00, q.mode};
                TMC_ADDR_CNT_LO: s.rdata = q.count[7:0];
                TMC_ADDR_CNT_HI: s.rdata = q.count[15:8];
                TMC_ADDR_RLD_LO: s.rdata = q.reload[7:0];
                TMC_ADDR_RLD_HI: s.rdata = q.reload[15:8];
                default: s.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            q <= '0; // RULE12
        end else begin
            q <= s;
        end
    end

    assign o_sfr_rdata = q.rdata;
    assign o_count_pin = q.clk_pin;
    assign o_count_pin_oe = q.mode[TMC_BIT_CLKOE]; // RULE15
    assign o_rx_clock_tick = q.rx_tick;
    assign o_tx_clock_tick = q.tx_tick;
    assign o_irq = q.irq;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    a_run_hold: assert property (!q.ctrl[TMC_BIT_RUN] && !i_sfr_wr && !pin.trig_fall // RULE10
        |=> $stable(q.count)) else $error("count moved while stopped");
    a_ovf_flag_set: assert property (ovf && !baud && !clkout // RULE4
        |=> q.ctrl[TMC_BIT_OVF]) else $error("overflow flag not set");
    a_baud_no_flag: assert property (baud && !q.ctrl[TMC_BIT_OVF] && !wr_ctrl && !i_bit_wr // RULE4
        |=> !q.ctrl[TMC_BIT_OVF]) else $error("flag set in serial clock mode");
    a_rx_select: assert property (q.ctrl[TMC_BIT_RXSEL] && ovf // RULE7
        |=> o_rx_clock_tick) else $error("receive tick missing");
    a_tx_select: assert property (!q.ctrl[TMC_BIT_TXSEL] && !i_t1_ovf // RULE8
        |=> !o_tx_clock_tick) else $error("transmit tick from wrong source");
    a_ext_gate: assert property (!q.ctrl[TMC_BIT_EXEN] && !updown && !q.ctrl[TMC_BIT_EXT] // RULE9
        && !wr_ctrl && !i_bit_wr |=> !q.ctrl[TMC_BIT_EXT]) else $error("trigger not ignored");
    a_irq_ext: assert property (q.ctrl[TMC_BIT_EXT] && !q.mode[TMC_BIT_DOWN_COUNT_ENABLE] // RULE6
        |-> o_irq) else $error("external flag gives no request");
    a_reload_ovf: assert property (ovf && !q.ctrl[TMC_BIT_CAPSEL] && !i_sfr_wr && !trig_ev // RULE13
        |=> q.count == $past(q.reload)) else $error("no reload on overflow");
    a_clkout_toggle: assert property (ovf && clkout // RULE14
        |=> o_count_pin != $past(o_count_pin)) else $error("clock pin not toggled");
    a_bit_write: assert property (i_bit_wr && !wr_ctrl && i_bit_idx == 3'h2 // RULE12
        |=> q.ctrl[TMC_BIT_RUN] == $past(i_bit_val)) else $error("bit write lost");
    a_ext_flag_set: assert property (trig_ev // RULE5
        |=> q.ctrl[TMC_BIT_EXT]) else $error("external flag not set");
    // Software writes excluded: a byte write wins over the hardware load
    a_trig_reload: assert property (trig_ev && !q.ctrl[TMC_BIT_CAPSEL] && !i_sfr_wr // RULE13
        |=> q.count == $past(q.reload)) else $error("no reload on trigger");
    a_trig_capture: assert property (trig_ev && q.ctrl[TMC_BIT_CAPSEL] && !clkout // RULE13
        && !i_sfr_wr |=> q.reload == $past(q.count)) else $error("no capture on trigger");
    a_down_wrap: assert property (unf && !i_sfr_wr // RULE16
        |=> q.count == TMC_COUNT_MAX) else $error("underflow did not load all ones");
    a_stop_presc: assert property (!q.ctrl[TMC_BIT_RUN] // RULE10
        |=> q.presc == '0) else $error("prescaler moved while stopped");
    a_pin_hold: assert property (!clkout // RULE14
        |=> $stable(o_count_pin)) else $error("clock pin moved outside clock-out mode");

endmodule // tmc_timer2

`default_nettype wire

// ==== testbench/tmc_far_side.sv ====
`timescale 1ns/100ps
`default_nettype none

// =============================
// Pins and serial port beside the timer
module tmc_far_side (
    input wire logic i_clock,   // Oscillator clock
    input wire logic i_rx_tick, // Receive baud tick
    input wire logic i_tx_tick, // Transmit baud tick
    output logic o_trig_pin,    // Trigger pin level
    output logic o_count_pin    // Count pin level while released
);
    int rx_n = 0;
    int tx_n = 0;
    initial begin
        o_trig_pin = 1'b1;
        o_count_pin = 1'b1;
    end
    always @(posedge i_clock) begin
        rx_n <= rx_n + int'(i_rx_tick === 1'b1);
        tx_n <= tx_n + int'(i_tx_tick === 1'b1);
    end
    // Held four clocks each way so the synchroniser sees both levels
    task automatic fall_trig();
        o_trig_pin = 1'b0;
        repeat (4) @(posedge i_clock);
        #2;
        o_trig_pin = 1'b1;
        repeat (4) @(posedge i_clock);
        #2;
    endtask
    task automatic fall_count();
        o_count_pin = 1'b0;
        repeat (4) @(posedge i_clock);
        #2;
        o_count_pin = 1'b1;
        repeat (4) @(posedge i_clock);
        #2;
    endtask
    task automatic set_trig(input logic v);
        o_trig_pin = v;
    endtask
endmodule // tmc_far_side

`default_nettype wire

// ==== testbench/timer2_control_logic_bench.sv ====
`timescale 1ns/100ps
`default_nettype none

module timer2_control_logic_bench;
    import tmc_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic swr = 1'b0;
    logic srd = 1'b0;
    logic bwr = 1'b0;
    logic [2:0] bidx = 3'h0;
    logic bval = 1'b0;
    logic t1 = 1'b0;
    logic [7:0] rdata;
    logic pin;
    logic oe;
    logic rxt;
    logic txt;
    logic irq;
    logic trig;
    logic fcnt;
    logic cnt_in;
    int err_total = 0;
    int n_checks = 0;

    // Wire level from both parties of the count pin
    assign cnt_in = (oe === 1'b1) ? pin : fcnt;
    always #10 clk = ~clk;

    tmc_timer2 uut (.i_clock(clk), .i_nrst(nrst), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
        .i_sfr_wr(swr), .i_sfr_rd(srd), .i_bit_wr(bwr), .i_bit_idx(bidx), .i_bit_val(bval),
        .i_trig_pin(trig), .i_count_pin(cnt_in), .i_t1_ovf(t1), .o_sfr_rdata(rdata),
        .o_count_pin(pin), .o_count_pin_oe(oe), .o_rx_clock_tick(rxt),
        .o_tx_clock_tick(txt), .o_irq(irq));
    tmc_far_side fp (.i_clock(clk), .i_rx_tick(rxt), .i_tx_tick(txt),
        .o_trig_pin(trig), .o_count_pin(fcnt));

    // =============================
    // Bus and check helpers
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        addr = a;
        wdata = d;
        swr = 1'b1;
        cyc(1);
        swr = 1'b0;
    endtask
    task automatic bw(input logic [2:0] i, input logic v);
        cyc(1);
        bidx = i;
        bval = v;
        bwr = 1'b1;
        cyc(1);
        bwr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        cyc(1);
        addr = a;
        srd = 1'b1;
        cyc(1);
        srd = 1'b0;
        d = rdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d, e);
    endtask
    task automatic ld(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h01, v[15:8]);
    endtask

    // =============================
    // Scenarios
    task automatic s_reset_bits();
        rc(TMC_ADDR_CONTROL, 8'h00);
        rc(TMC_ADDR_MODE, 8'h00);
        bw(3'h2, 1'b1);
        rc(TMC_ADDR_CONTROL, 8'h04);
        bw(3'h2, 1'b0);
    endtask
    task automatic s_overflow();
        logic [7:0] v;
        int n;
        ld(TMC_ADDR_CNT_LO, 16'hFFFF);
        ld(TMC_ADDR_RLD_LO, 16'h1234);
        bw(3'h2, 1'b1);
        n = 0;
        while (irq !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        chk({7'h0, irq}, 8'h01);
        if (n == 40) stop_test();
        bw(3'h2, 1'b0);
        rc(TMC_ADDR_CONTROL, 8'h80);
        rc(TMC_ADDR_CNT_HI, 8'h12);
        rd(TMC_ADDR_CNT_LO, v);
        cyc(30);
        rc(TMC_ADDR_CNT_LO, v);
        bw(3'h7, 1'b0);
        cyc(2);
        chk({7'h0, irq}, 8'h00);
    endtask
    task automatic s_clock_and_baud();
        logic p;
        int n;
        int r0;
        int r1;
        wr(TMC_ADDR_MODE, 8'h02);
        ld(TMC_ADDR_RLD_LO, 16'hFFFE);
        ld(TMC_ADDR_CNT_LO, 16'hFFFE);
        wr(TMC_ADDR_CONTROL, 8'h34);
        cyc(2);
        chk({7'h0, oe}, 8'h01);
        r0 = fp.rx_n;
        r1 = fp.tx_n;
        for (int k = 0; k < 2; k++) begin
            p = pin;
            n = 0;
            while (pin === p && n < 20) begin
                cyc(1);
                n++;
            end
        end
        chk(8'(n), 8'h04);
        if (n == 20) stop_test();
        chk({7'h0, fp.rx_n > r0}, 8'h01);
        chk({7'h0, fp.tx_n > r1}, 8'h01);
        rc(TMC_ADDR_CONTROL, 8'h34);
        wr(TMC_ADDR_CONTROL, 8'h00);
        wr(TMC_ADDR_MODE, 8'h00);
        cyc(2);
        chk({7'h0, oe}, 8'h00);
        r0 = fp.rx_n;
        r1 = fp.tx_n;
        t1 = 1'b1;
        cyc(1);
        t1 = 1'b0;
        cyc(3);
        chk(8'(fp.rx_n - r0), 8'h01);
        chk(8'(fp.tx_n - r1), 8'h01);
    endtask
    task automatic s_trigger();
        ld(TMC_ADDR_RLD_LO, 16'hABCD);
        ld(TMC_ADDR_CNT_LO, 16'h0000);
        wr(TMC_ADDR_CONTROL, 8'h08);
        fp.fall_trig();
        cyc(3);
        rc(TMC_ADDR_CNT_LO, 8'hCD);
        rc(TMC_ADDR_CONTROL, 8'h48);
        chk({7'h0, irq}, 8'h01);
        bw(3'h6, 1'b0);
        wr(TMC_ADDR_CNT_LO, 8'h66);
        wr(TMC_ADDR_CONTROL, 8'h09);
        fp.fall_trig();
        cyc(3);
        rc(TMC_ADDR_RLD_LO, 8'h66);
        rc(TMC_ADDR_CONTROL, 8'h49);
        wr(TMC_ADDR_CONTROL, 8'h38);
        fp.fall_trig();
        rc(TMC_ADDR_CONTROL, 8'h38);
        wr(TMC_ADDR_CONTROL, 8'h01);
        fp.fall_trig();
        cyc(3);
        rc(TMC_ADDR_CONTROL, 8'h01);
    endtask
    task automatic s_count_pin();
        ld(TMC_ADDR_CNT_LO, 16'h0000);
        wr(TMC_ADDR_CONTROL, 8'h06);
        repeat (3) fp.fall_count();
        cyc(4);
        bw(3'h2, 1'b0);
        rc(TMC_ADDR_CNT_LO, 8'h03);
    endtask
    task automatic s_up_down();
        wr(TMC_ADDR_MODE, 8'h01);
        ld(TMC_ADDR_RLD_LO, 16'h0005);
        ld(TMC_ADDR_CNT_LO, 16'h0006);
        fp.set_trig(1'b0);
        wr(TMC_ADDR_CONTROL, 8'h04);
        cyc(40);
        bw(3'h2, 1'b0);
        rc(TMC_ADDR_CNT_HI, 8'hFF);
        rc(TMC_ADDR_CONTROL, 8'hC0);
        bw(3'h7, 1'b0);
        cyc(2);
        chk({7'h0, irq}, 8'h00);
        fp.set_trig(1'b1);
        bw(3'h2, 1'b1);
        cyc(30);
        bw(3'h2, 1'b0);
        rc(TMC_ADDR_CNT_LO, 8'h05);
        rc(TMC_ADDR_CONTROL, 8'h80);
        bw(3'h7, 1'b0);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        #2 nrst = 1'b1;
        s_reset_bits();
        s_overflow();
        s_clock_and_baud();
        s_trigger();
        s_count_pin();
        s_up_down();
        stop_test();
    end
    initial begin
        repeat (90000) @(posedge clk);
        err_total++;
        stop_test();
    end
endmodule // timer2_control_logic_bench

`default_nettype wire
